// ---- rrsr_pkg.sv ----
// Package for the regulator, timer and signal-strength register bank
// Functional notes
// [RULE1] Source bit picks adjust result or field
// [RULE2] Voltage field: codes 0101 to 1111 valid
// [RULE3] Supply field picks main, analog, digital, driver
// [RULE4] Control register zero at reset, set-default
// [RULE5] Display bits 7:4 show applied setting
// [RULE6] Display bit 2: general timer running
// [RULE7] Display bit 1: no-response timer running
// [RULE8] Display bit 0: mask-receive timer running
// [RULE9] Bits 7:4 hold AM peak level
// [RULE10] Bits 3:0 hold PM peak level
// [RULE11] Peaks clear at message start, clear command
// [RULE12] Signal-strength register zero after reset, default
// [RULE13] Channel indicator shows which level logic uses
// [RULE14] Level codes monotonic, 1110 and 1111 top
// [RULE15] Unused control bit 0, display bit 3 read 0
// [RULE16] Writes to read-only registers change nothing
package rrsr_pkg;
  localparam logic [11:0] RRSR_CTRL_ADDR  = 12'h0a8;
  localparam logic [11:0] RRSR_DISP_ADDR  = 12'h0ac;
  localparam logic [11:0] RRSR_LEVEL_ADDR = 12'h0b0;
  localparam logic [7:0]  RRSR_CTRL_INDEX  = 8'h2a;
  localparam logic [7:0]  RRSR_DISP_INDEX  = 8'h2b;
  localparam logic [7:0]  RRSR_LEVEL_INDEX = 8'h2c;
  localparam logic [7:0]  RRSR_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  RRSR_LEVEL_RESET = 8'h00;
  localparam logic [7:0]  RRSR_CTRL_MASK   = 8'hfe;
  localparam int          RRSR_SRC_BIT     = 7;
  localparam int          RRSR_VOLT_HI     = 6;
  localparam int          RRSR_VOLT_LO     = 3;
  localparam int          RRSR_SUP_HI      = 2;
  localparam int          RRSR_SUP_LO      = 1;
  localparam logic [3:0]  RRSR_VOLT_MIN    = 4'h5;
  localparam logic [3:0]  RRSR_LEVEL_ZERO  = 4'h0;
  typedef enum logic [1:0]
  {
    RRSR_SUP_MAIN   = 2'b00,
    RRSR_SUP_ANALOG = 2'b01,
    RRSR_SUP_DIGIT  = 2'b10,
    RRSR_SUP_DRIVER = 2'b11
  } rrsr_supply_t;
endpackage

// ---- rrsr_peak.sv ----
// Peak hold of one 4-bit signal-strength channel
`timescale 1ns/1ps
`default_nettype none
module rrsr_peak
  import rrsr_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       sample_valid,
  input  wire logic [3:0] sample,
  output logic      [3:0] peak
);
  wire logic [3:0] next_peak;
  wire logic       higher;

  // Codes are monotonic, so a plain compare finds the peak
  assign higher    = sample_valid && (sample > peak); // see [RULE14]
  // A clear in the same cycle as a sample restarts from that sample
  assign next_peak = clear ? (sample_valid ? sample : RRSR_LEVEL_ZERO)
                           : (higher ? sample : peak); // see [RULE11]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      peak <= RRSR_LEVEL_ZERO; // see [RULE12]
    else
      peak <= next_peak;
  end

  peak_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE9] [RULE10]
    !$past(clear) && $past(sample_valid) |-> peak >= $past(sample))
    else $error("peak fell below a seen sample");
endmodule
`default_nettype wire

// ---- rrsr_regs.sv ----
// Regulator, timer and signal-strength register bank with APB slave
`timescale 1ns/1ps
`default_nettype none
module rrsr_regs
  import rrsr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        set_default,
  input  wire logic        clear_level_cmd,
  input  wire logic        message_start,
  input  wire logic [3:0]  adjust_result,
  input  wire logic        gp_timer_running,
  input  wire logic        no_resp_timer_running,
  input  wire logic        mask_rx_timer_running,
  input  wire logic        am_level_valid,
  input  wire logic [3:0]  am_level,
  input  wire logic        pm_level_valid,
  input  wire logic [3:0]  pm_level,
  input  wire logic        pm_channel_selected,
  output logic      [3:0]  applied_voltage,
  output logic      [1:0]  supply_measure_source,
  output logic      [3:0]  selected_level,
  output logic             selected_channel
);
  logic       [7:0] ctrl;
  logic       [3:0] timers;
  wire logic  [3:0] am_peak;
  wire logic  [3:0] pm_peak;
  wire logic        setup;
  wire logic        wr_ctrl;
  wire logic        hit_ctrl;
  wire logic        hit_disp;
  wire logic        hit_level;
  wire logic        mapped;
  wire logic  [3:0] ext_voltage;
  wire logic        ext_legal;
  wire logic  [3:0] next_applied;
  wire logic  [7:0] disp_value;
  wire logic  [7:0] level_value;
  wire logic  [7:0] next_rdata;
  wire logic        level_clear;

  // Answer at the access cycle, one wait-free APB beat
  assign setup     = psel && !penable;
  assign hit_ctrl  = paddr == RRSR_CTRL_ADDR;
  assign hit_disp  = paddr == RRSR_DISP_ADDR;
  assign hit_level = paddr == RRSR_LEVEL_ADDR;
  assign mapped    = hit_ctrl || hit_disp || hit_level;
  // Writes to read-only words are dropped silently
  assign wr_ctrl   = psel && penable && pready && pwrite && hit_ctrl
                     && pstrb[0]; // see [RULE16]

  assign ext_voltage = ctrl[RRSR_VOLT_HI:RRSR_VOLT_LO]; // see [RULE2]
  // Unused codes below 0101 clamp to the lowest step
  assign ext_legal   = ext_voltage >= RRSR_VOLT_MIN; // see [RULE2]
  assign next_applied = ctrl[RRSR_SRC_BIT]
                        ? (ext_legal ? ext_voltage : RRSR_VOLT_MIN)
                        : adjust_result; // see [RULE1]

  assign disp_value  = {applied_voltage, timers}; // see [RULE5]
  assign level_value = {am_peak, pm_peak}; // see [RULE9] [RULE10]
  assign next_rdata  = hit_ctrl ? ctrl
                     : hit_disp ? disp_value
                     : hit_level ? level_value
                     : RRSR_LEVEL_RESET;
  assign level_clear = message_start || clear_level_cmd
                       || set_default; // see [RULE11] [RULE12]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= RRSR_CTRL_RESET; // see [RULE4]
    else if (set_default)
      ctrl <= RRSR_CTRL_RESET; // see [RULE4]
    else if (wr_ctrl)
      ctrl <= pwdata[7:0] & RRSR_CTRL_MASK; // see [RULE15]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
        prdata <= {24'h000000, next_rdata};
    end
  end

  // Bit 3 stays zero as unused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timers <= 4'h0;
    else
      timers <= {1'b0, gp_timer_running, no_resp_timer_running,
                 mask_rx_timer_running}; // see [RULE6] [RULE7] [RULE8]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      applied_voltage       <= 4'h0;
      supply_measure_source <= RRSR_SUP_MAIN;
      selected_level        <= RRSR_LEVEL_ZERO;
      selected_channel      <= 1'b0;
    end
    else
    begin
      applied_voltage       <= next_applied; // see [RULE1]
      supply_measure_source <= ctrl[RRSR_SUP_HI:RRSR_SUP_LO]; // see [RULE3]
      selected_level        <= pm_channel_selected ? pm_peak
                                                   : am_peak; // see [RULE13]
      selected_channel      <= pm_channel_selected; // see [RULE13]
    end
  end

  rrsr_peak u_am_peak
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .clear        (level_clear),
    .sample_valid (am_level_valid),
    .sample       (am_level),
    .peak         (am_peak)
  );

  rrsr_peak u_pm_peak
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .clear        (level_clear),
    .sample_valid (pm_level_valid),
    .sample       (pm_level),
    .peak         (pm_peak)
  );

  ctrl_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(set_default) |-> ctrl == RRSR_CTRL_RESET) // see [RULE4]
    else $error("control not cleared by default");
  ctrl_unused_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[0] == 1'b0) // see [RULE15]
    else $error("unused control bit set");
  src_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl[RRSR_SRC_BIT]) && $past(ext_legal)
    |-> applied_voltage == $past(ext_voltage)) // see [RULE1]
    else $error("applied voltage ignores external field");
  src_adj_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    !$past(ctrl[RRSR_SRC_BIT]) |-> applied_voltage == $past(adjust_result))
    else $error("applied voltage ignores adjust result");
  supply_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
    supply_measure_source == $past(ctrl[RRSR_SUP_HI:RRSR_SUP_LO]))
    else $error("supply source mismatch");
  timer_flags_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE6] [RULE7] [RULE8]
    ##1 timers == {1'b0, $past(gp_timer_running),
    $past(no_resp_timer_running), $past(mask_rx_timer_running)})
    else $error("timer flags wrong");
  disp_unused_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE15]
    disp_value[3] == 1'b0)
    else $error("unused display bit set");
  level_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(level_clear) && !$past(am_level_valid)
    && !$past(pm_level_valid) |-> level_value == 8'h00) // see [RULE11]
    else $error("peak levels not cleared");
  ro_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(psel && penable && pwrite && !hit_ctrl) && !$past(set_default)
    |-> $stable(ctrl)) // see [RULE16]
    else $error("read-only write changed control");
endmodule
`default_nettype wire

// ---- rrsr_far.sv ----
// Far-side model: regulator adjust, timers and receive channels
`timescale 1ns/1ps
`default_nettype none
module rrsr_far
(
  input  wire logic       pclk,
  output logic      [3:0] adjust_result,
  output logic      [2:0] timers,
  output logic            am_v,
  output logic      [3:0] am,
  output logic            pm_v,
  output logic      [3:0] pm,
  output logic            pm_sel
);
  initial
  begin
    {adjust_result, timers, am_v, am, pm_v, pm, pm_sel} = '0;
  end
  task state(input logic [3:0] adj, input logic [2:0] t, input logic s);
    @(posedge pclk);
    adjust_result <= adj;
    timers <= t;
    pm_sel <= s;
  endtask
  // Released lines show the inverse so a stale sample cannot pass
  task send(input logic [3:0] a, input logic [3:0] p);
    @(posedge pclk);
    am_v <= 1'b1;
    am <= a;
    pm_v <= 1'b1;
    pm <= p;
    @(posedge pclk);
    am_v <= 1'b0;
    am <= ~a;
    pm_v <= 1'b0;
    pm <= ~p;
  endtask
endmodule
`default_nettype wire

// ---- tb_regulator_rssi_status_regs.sv ----
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_regulator_rssi_status_regs
  import rrsr_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h29;
  logic [3:0]  pstrb = 4'hf, adj, am, pm, applied_voltage, selected_level;
  logic [2:0]  cmd = '0, tmr;
  logic [1:0]  supply_measure_source;
  logic pready, pslverr, am_v, pm_v, pm_sel, selected_channel;
  logic [9:0]  q[$];
  logic [9:0]  n;
  logic [3:0]  v;
  int bad_count = 0, compares = 0;
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  rrsr_far u_far (.pclk(pclk), .adjust_result(adj), .timers(tmr),
    .am_v(am_v), .am(am), .pm_v(pm_v), .pm(pm), .pm_sel(pm_sel));
  rrsr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .set_default(cmd[0]), .clear_level_cmd(cmd[1]),
    .message_start(cmd[2]), .adjust_result(adj),
    .gp_timer_running(tmr[2]), .no_resp_timer_running(tmr[1]),
    .mask_rx_timer_running(tmr[0]), .am_level_valid(am_v),
    .am_level(am), .pm_level_valid(pm_v), .pm_level(pm),
    .pm_channel_selected(pm_sel), .applied_voltage(applied_voltage),
    .supply_measure_source(supply_measure_source),
    .selected_level(selected_level), .selected_channel(selected_channel));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string s, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Note: {check data, expect error, data}
  task apb(input logic w, input logic [11:0] a, input logic [9:0] e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, e[7:0]};
    q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      bad_count++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input logic [2:0] c);
    @(posedge pclk);
    cmd <= c;
    @(posedge pclk);
    cmd <= '0;
    repeat (2) @(posedge pclk);
  endtask
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && q.size() > 0)
    begin
      n = q.pop_front();
      chk("pslverr", {8'h0, n[8]}, {8'h0, pslverr});
      if (n[9])
        chk("prdata", {1'b0, n[7:0]}, prdata[8:0]);
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    u_far.state(4'h9, 3'b101, 1'b0);
    repeat (3) @(posedge pclk);
    apb(0, RRSR_CTRL_ADDR, 10'h200);
    apb(0, RRSR_LEVEL_ADDR, 10'h200);
    apb(0, RRSR_DISP_ADDR, 10'h295);
    chk("applied", 9'h9, {5'h0, applied_voltage});
    u_far.state(4'h9, 3'b010, 1'b0);
    repeat (3) @(posedge pclk);
    apb(0, RRSR_DISP_ADDR, 10'h292);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      v = xs();
      apb(1, RRSR_CTRL_ADDR, {2'b00, 1'b1, v, i[1:0], 1'b1});
      apb(0, RRSR_CTRL_ADDR, {2'b10, 1'b1, v, i[1:0], 1'b0});
      chk("supply", {7'h0, i[1:0]}, {7'h0, supply_measure_source});
      chk("applied", {5'h0, (v < 4'h5) ? 4'h5 : v},
          {5'h0, applied_voltage});
    end
    $display("test control done");
    // Low byte strobe off: the control word must keep its value
    pstrb <= 4'he;
    apb(1, RRSR_CTRL_ADDR, 10'h000);
    pstrb <= 4'hf;
    apb(0, RRSR_CTRL_ADDR, {2'b10, 1'b1, v, 2'b11, 1'b0});
    apb(1, RRSR_DISP_ADDR, 10'h0ff);
    apb(1, RRSR_LEVEL_ADDR, 10'h0ff);
    apb(1, 12'h0b4, 10'h1ff);
    apb(0, RRSR_LEVEL_ADDR, 10'h200);
    $display("test read-only done");
    u_far.send(4'h3, 4'h5);
    u_far.send(4'h7, 4'h1);
    u_far.send(4'h2, 4'h4);
    u_far.state(4'h9, 3'b000, 1'b1);
    repeat (3) @(posedge pclk);
    apb(0, RRSR_LEVEL_ADDR, 10'h275);
    chk("sel_level", 9'h5, {5'h0, selected_level});
    chk("sel_chan", 9'h1, {8'h0, selected_channel});
    for (int c = 1; c < 3; c++)
    begin
      u_far.send(4'he, 4'hf);
      pulse(3'b001 << c);
      apb(0, RRSR_LEVEL_ADDR, 10'h200);
    end
    u_far.send(4'h6, 4'h2);
    pulse(3'b001);
    apb(0, RRSR_CTRL_ADDR, 10'h200);
    apb(0, RRSR_LEVEL_ADDR, 10'h200);
    $display("test peaks done");
    summarize();
  end
endmodule
`default_nettype wire
